// file: rtl/fiap_pkg.sv
// Constants and types shared by the flash write and erase sequencer ends
package fiap_pkg;
  // Address map
  localparam logic [15:0] ADDR_LOW = 16'h0000;
  localparam logic [15:0] ADDR_HIGH = 16'h7fff;
  localparam logic [15:0] CFG_ADDR = 16'h7fff;
  localparam logic [15:0] IAP_BASE = 16'h7a00;
  localparam logic [15:0] IAP_LAST = 16'h7dff;
  localparam logic [15:0] PAGE_LO_BASE = 16'h7a00;
  localparam logic [15:0] PAGE_HI_BASE = 16'h7c00;
  localparam logic [15:0] TRIG_LO = 16'h7b2d;
  localparam logic [15:0] TRIG_HI = 16'h7d69;
  localparam int PAGE_BYTES = 512;
  localparam int IAP_BYTES = 1024;
  // Unlock key values
  localparam logic [7:0] CMD_KEY = 8'h65;
  localparam logic [7:0] WE_WRITE_LO = 8'h4a;
  localparam logic [7:0] WE_ERASE_LO = 8'hba;
  localparam logic [7:0] WE_WRITE_HI = 8'h4c;
  localparam logic [7:0] WE_ERASE_HI = 8'hbc;
  localparam logic [7:0] KEY_OFF = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] CFG_RESET = 8'hff;
  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int WRITE_TIME_NS = 20_000;
  localparam int ERASE_TIME_US = 2_000;
  localparam int WRITE_CYCLES = WRITE_TIME_NS / (1_000_000_000 / CLK_HZ);
  localparam int ERASE_CYCLES = ERASE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int TIMER_W = 16;
  // Sequencer states
  typedef enum logic [1:0] {
    FIAP_IDLE = 2'b00,
    FIAP_WRITE = 2'b01,
    FIAP_ERASE = 2'b10
  } fiap_state_t;
endpackage

// file: rtl/fiap_if.sv
// Interface joining the CPU end and the flash sequencer end
`timescale 1ns/1ps
interface fiap_if;
  logic xwr_valid; // External-data write strobe
  logic [15:0] xwr_addr; // Data pointer value
  logic [7:0] xwr_data; // Accumulator value
  logic [15:0] code_addr; // Code read address
  logic [7:0] code_data; // Code read data
  logic [7:0] iap_command_key; // Command key register
  logic [7:0] iap_write_enable_key; // Write-enable key register
  logic cpu_wait; // Stall request to CPU
  modport device (
    input xwr_valid, xwr_addr, xwr_data, code_addr, iap_command_key, iap_write_enable_key,
    output code_data, cpu_wait
  );
  modport cpu (
    output xwr_valid, xwr_addr, xwr_data, code_addr, iap_command_key, iap_write_enable_key,
    input code_data, cpu_wait
  );
endinterface

// file: rtl/fiap_timer.sv
// Down counter that times one flash write or erase
`timescale 1ns/1ps
module fiap_timer (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [fiap_pkg::TIMER_W-1:0] count,
  output logic busy
);
  logic [fiap_pkg::TIMER_W-1:0] remain; // Cycles left

  // Load wins over counting, reaches zero after count cycles
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      remain <= '0;
    end else if (load) begin
      remain <= count;
    end else if (remain != '0) begin
      remain <= remain - 16'h0001;
    end
  end

  assign busy = (remain != '0);
endmodule

// file: rtl/fiap_device.sv
// Flash sequencer end: address decode, key check, byte write, page erase
`timescale 1ns/1ps
module fiap_device (
  input wire logic sys_clk,
  input wire logic sys_rst,
  fiap_if.device bus,
  output logic [7:0] configuration_word,
  output logic busy,
  output logic [7:0] ignored_count
);
  // Programmable area storage, two pages back to back
  // Starts blank; after that only the storage process writes it
  logic [7:0] iap_mem [0:fiap_pkg::IAP_BYTES-1] = '{default: fiap_pkg::ERASED_BYTE};
  // Fixed program image outside the programmable area
  logic [7:0] rom_mem [0:fiap_pkg::IAP_BYTES-1];
  fiap_pkg::fiap_state_t state; // Sequencer state
  fiap_pkg::fiap_state_t next_state; // Next sequencer state
  logic [9:0] op_index; // Latched byte index in area
  logic [7:0] op_data; // Latched byte data
  logic op_page; // Latched page, 1 = upper
  logic [9:0] erase_ptr; // Byte being erased
  logic cfg_loaded; // Configuration captured after reset
  logic timer_busy; // Operation time still running
  logic timer_load; // Start timing
  logic [fiap_pkg::TIMER_W-1:0] timer_count; // Duration in cycles
  logic [7:0] code_q; // Registered code read data

  // Area membership test used for both buses
  function automatic logic in_area(input logic [15:0] a);
    in_area = (a >= fiap_pkg::IAP_BASE) && (a <= fiap_pkg::IAP_LAST);
  endfunction

  // Byte index inside the area; upper page lands at 512 and up
  function automatic logic [9:0] area_index(input logic [15:0] a);
    area_index = a[9:0] - fiap_pkg::IAP_BASE[9:0];
  endfunction

  // Decode of the write request
  wire in_range = (bus.xwr_addr <= fiap_pkg::ADDR_HIGH);
  wire wr_area = in_range && in_area(bus.xwr_addr);
  wire wr_upper = bus.xwr_addr[10]; // 7Cxx-7Dxx have bit 10 set
  wire cmd_ok = (bus.iap_command_key == fiap_pkg::CMD_KEY);
  wire key_wr_lo = cmd_ok && (bus.iap_write_enable_key == fiap_pkg::WE_WRITE_LO);
  wire key_er_lo = cmd_ok && (bus.iap_write_enable_key == fiap_pkg::WE_ERASE_LO);
  wire key_wr_hi = cmd_ok && (bus.iap_write_enable_key == fiap_pkg::WE_WRITE_HI);
  wire key_er_hi = cmd_ok && (bus.iap_write_enable_key == fiap_pkg::WE_ERASE_HI);
  wire idle = (state == fiap_pkg::FIAP_IDLE);
  // Erase armed and aimed at the page's trigger address
  wire go_erase = idle && bus.xwr_valid && wr_area
    && ((!wr_upper && key_er_lo && bus.xwr_addr == fiap_pkg::TRIG_LO)
    || (wr_upper && key_er_hi && bus.xwr_addr == fiap_pkg::TRIG_HI));
  // Byte write armed for the page that holds the address
  wire go_write = idle && bus.xwr_valid && wr_area
    && ((!wr_upper && key_wr_lo) || (wr_upper && key_wr_hi));
  // Anything else on the strobe is dropped without a stall
  wire refused = idle && bus.xwr_valid && !go_erase && !go_write;
  wire [9:0] req_index = area_index(bus.xwr_addr);

  // One timer serves both operations; erase gets the long count
  assign timer_load = go_write || go_erase;
  assign timer_count = go_erase ? fiap_pkg::TIMER_W'(fiap_pkg::ERASE_CYCLES)
    : fiap_pkg::TIMER_W'(fiap_pkg::WRITE_CYCLES);

  fiap_timer u_timer (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .load(timer_load),
    .count(timer_count),
    .busy(timer_busy)
  );

  // Next state: leave operation when its time expires
  always_comb begin
    next_state = state;
    unique case (state)
      fiap_pkg::FIAP_IDLE: begin
        // Erase first: the trigger address is also a writable byte
        if (go_erase) begin
          next_state = fiap_pkg::FIAP_ERASE;
        end else if (go_write) begin
          next_state = fiap_pkg::FIAP_WRITE;
        end
      end
      fiap_pkg::FIAP_WRITE, fiap_pkg::FIAP_ERASE: begin
        // Strobes seen here are refused, the device is busy
        if (!timer_busy) begin
          next_state = fiap_pkg::FIAP_IDLE;
        end
      end
      default: begin
        // Unused code recovers to idle
        next_state = fiap_pkg::FIAP_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= fiap_pkg::FIAP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Latch the operation when accepted
  // Held here so the cpu end may change its bus after acceptance
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      op_index <= '0;
      op_data <= '0;
      op_page <= 1'b0;
    end else if (go_write || go_erase) begin
      op_index <= req_index;
      op_data <= bus.xwr_data;
      op_page <= wr_upper;
    end
  end

  // Erase walks one byte per cycle; 512 cycles fit well inside 2 ms
  // Pointer parks on the page's last byte until the timer ends
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      erase_ptr <= '0;
    end else if (go_erase) begin
      erase_ptr <= {wr_upper, 9'h000};
    end else if (state == fiap_pkg::FIAP_ERASE && erase_ptr[8:0] != 9'h1ff) begin
      erase_ptr <= erase_ptr + 10'h001;
    end
  end

  // Storage update; no reset on the array, contents persist like flash
  always_ff @(posedge sys_clk) begin
    if (state == fiap_pkg::FIAP_ERASE) begin
      // Page comes from the latched request, the pointer gives the byte
      iap_mem[{op_page, erase_ptr[8:0]}] <= fiap_pkg::ERASED_BYTE;
    end else if (state == fiap_pkg::FIAP_WRITE && !timer_busy) begin
      // Lands in the last busy cycle, after the full write time
      // Flash only pulls bits low, so a second write cannot set bits
      iap_mem[op_index] <= iap_mem[op_index] & op_data;
    end
  end

  // Code reads come from the area or the fixed image, no unlock needed
  // Read port stays free during an operation; reads never stall
  wire [9:0] rd_index = area_index(bus.code_addr);
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      code_q <= '0;
    end else if (in_area(bus.code_addr)) begin
      code_q <= iap_mem[rd_index];
    end else begin
      code_q <= rom_mem[bus.code_addr[9:0]];
    end
  end
  assign bus.code_data = code_q;

  // Capture configuration byte in the cycle after reset release
  // Reset value matches a blank image, so a blank part reads the same
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg_loaded <= 1'b0;
      configuration_word <= fiap_pkg::CFG_RESET;
    end else if (!cfg_loaded) begin
      cfg_loaded <= 1'b1;
      configuration_word <= rom_mem[fiap_pkg::CFG_ADDR[9:0]];
    end
  end

  // Count refused writes for visibility
  // Only writes aimed at the area count; other data writes are ordinary
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ignored_count <= '0;
    end else if (refused && wr_area) begin
      ignored_count <= ignored_count + 8'h01;
    end
  end

  // Stall asserts combinationally on acceptance so the CPU never slips past
  assign bus.cpu_wait = go_write || go_erase || !idle;
  // Registered view of the operation, for logic that keeps running
  assign busy = !idle;

  // Fixed image, blank by default
  initial begin
    for (int i = 0; i < fiap_pkg::IAP_BYTES; i++) begin
      rom_mem[i] = fiap_pkg::ERASED_BYTE;
    end
  end
endmodule

// file: rtl/fiap_cpu.sv
// CPU end: turns user requests into keyed writes and code reads
`timescale 1ns/1ps
module fiap_cpu (
  input wire logic sys_clk,
  input wire logic sys_rst,
  fiap_if.cpu bus,
  input wire logic req_valid,
  input wire logic req_erase,
  input wire logic [15:0] req_addr,
  input wire logic [7:0] req_data,
  output logic req_ready,
  input wire logic [15:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [1:0] phase; // 0 idle, 1 strobe, 2 waiting
  logic [15:0] addr_q; // Held address
  logic [7:0] data_q; // Held data
  logic [7:0] cmd_q; // Command key
  logic [7:0] we_q; // Write-enable key

  wire upper = req_addr[10];
  wire [7:0] we_sel = req_erase ? (upper ? fiap_pkg::WE_ERASE_HI : fiap_pkg::WE_ERASE_LO)
    : (upper ? fiap_pkg::WE_WRITE_HI : fiap_pkg::WE_WRITE_LO);
  wire [15:0] addr_sel = req_erase ? (upper ? fiap_pkg::TRIG_HI : fiap_pkg::TRIG_LO)
    : req_addr;

  // Keys loaded, strobe one cycle, wait, then keys cleared
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phase <= 2'h0;
      addr_q <= '0;
      data_q <= '0;
      cmd_q <= fiap_pkg::KEY_OFF;
      we_q <= fiap_pkg::KEY_OFF;
    end else begin
      unique case (phase)
        2'h0: begin
          if (req_valid) begin
            phase <= 2'h1;
            addr_q <= addr_sel;
            data_q <= req_data;
            cmd_q <= fiap_pkg::CMD_KEY;
            we_q <= we_sel;
          end
        end
        2'h1: begin
          phase <= 2'h2;
        end
        default: begin
          if (!bus.cpu_wait) begin
            phase <= 2'h0;
            cmd_q <= fiap_pkg::KEY_OFF;
            we_q <= fiap_pkg::KEY_OFF;
          end
        end
      endcase
    end
  end

  assign bus.xwr_valid = (phase == 2'h1);
  assign bus.xwr_addr = addr_q;
  assign bus.xwr_data = data_q;
  assign bus.iap_command_key = cmd_q;
  assign bus.iap_write_enable_key = we_q;
  assign bus.code_addr = rd_addr;
  assign rd_data = bus.code_data;
  assign req_ready = (phase == 2'h0);
endmodule

// file: verification/fiap_chk.sv
// Interface assertions for the flash write and erase sequencer
`timescale 1ns/1ps
module fiap_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic xwr_valid,
  input wire logic [15:0] xwr_addr,
  input wire logic [7:0] iap_command_key,
  input wire logic [7:0] iap_write_enable_key,
  input wire logic cpu_wait
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  localparam int W = fiap_pkg::WRITE_CYCLES;
  localparam int E = fiap_pkg::ERASE_CYCLES;
  int len; // Cycles of the current stall
  logic kind_erase; // Running op is an erase
  wire key_ok = iap_command_key == fiap_pkg::CMD_KEY;
  wire in_lo = xwr_addr >= 16'h7a00 && xwr_addr <= 16'h7bff;
  wire in_hi = xwr_addr >= 16'h7c00 && xwr_addr <= 16'h7dff;
  // Stall length; erase keys have bit 7 set, write keys not
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      len <= 0;
      kind_erase <= 1'b0;
    end else begin
      len <= cpu_wait ? len + 1 : 0;
      if (xwr_valid && cpu_wait && len == 0) begin
        kind_erase <= iap_write_enable_key[7];
      end
    end
  end
  property p_wr_lo;
    xwr_valid && key_ok && iap_write_enable_key == fiap_pkg::WE_WRITE_LO && in_lo |-> cpu_wait;
  endproperty
  a_wr_lo: assert property (p_wr_lo) else $error("lower write not started");
  property p_wr_hi;
    xwr_valid && key_ok && iap_write_enable_key == fiap_pkg::WE_WRITE_HI && in_hi |-> cpu_wait;
  endproperty
  a_wr_hi: assert property (p_wr_hi) else $error("upper write not started");
  property p_er_lo;
    xwr_valid && key_ok && iap_write_enable_key == fiap_pkg::WE_ERASE_LO
      && xwr_addr == fiap_pkg::TRIG_LO |-> cpu_wait;
  endproperty
  a_er_lo: assert property (p_er_lo) else $error("lower erase not started");
  property p_er_hi;
    xwr_valid && key_ok && iap_write_enable_key == fiap_pkg::WE_ERASE_HI
      && xwr_addr == fiap_pkg::TRIG_HI |-> cpu_wait;
  endproperty
  a_er_hi: assert property (p_er_hi) else $error("upper erase not started");
  property p_refuse;
    xwr_valid && !$past(cpu_wait) && !(in_lo || in_hi) |-> !cpu_wait;
  endproperty
  a_refuse: assert property (p_refuse) else $error("stall outside pages");
  property p_hold;
    $rose(cpu_wait) |-> cpu_wait [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("stall dropped early");
  property p_wr_time;
    $fell(cpu_wait) && !kind_erase |-> len >= W && len <= W + 2;
  endproperty
  a_wr_time: assert property (p_wr_time) else $error("write time wrong");
  property p_er_time;
    $fell(cpu_wait) && kind_erase |-> len >= E && len <= E + 2;
  endproperty
  a_er_time: assert property (p_er_time) else $error("erase time wrong");
endmodule

// file: verification/testbench.sv
// Both sequencer ends joined, plus a lone device end fed bad strobes
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_erase = 1'b0;
  logic [15:0] req_addr = 16'h0000;
  logic [7:0] req_data = 8'h00;
  logic [15:0] rd_addr = 16'h0000;
  logic req_ready;
  logic [7:0] rd_data, cfg, cfg2, ign, ign2, e;
  logic busy, busy2, rd_go = 1'b0, rd_seen = 1'b0;
  logic [7:0] exp_q[$]; // Expected read data, oldest first
  logic [7:0] wd[4];
  logic [15:0] wa[4] = '{16'h7a00, 16'h7b2d, 16'h7c00, 16'h7dff};
  logic [31:0] rnd = 32'ha34ca2aa;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  fiap_if bus();
  fiap_if bus2(); // Lone device end, bench drives the far side
  fiap_cpu i_fiap_cpu (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus), .req_valid(req_valid),
    .req_erase(req_erase), .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready),
    .rd_addr(rd_addr), .rd_data(rd_data));
  fiap_device i_fiap_device (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus),
    .configuration_word(cfg), .busy(busy), .ignored_count(ign));
  fiap_device i_fiap_device_2 (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus2),
    .configuration_word(cfg2), .busy(busy2), .ignored_count(ign2));
  fiap_chk i_fiap_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .xwr_valid(bus.xwr_valid),
    .xwr_addr(bus.xwr_addr), .iap_command_key(bus.iap_command_key),
    .iap_write_enable_key(bus.iap_write_enable_key), .cpu_wait(bus.cpu_wait));
  always #50 sys_clk = ~sys_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task test_done;
    if (bad_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Three erases dominate: about 60k cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 70000) begin
      bad_count++;
      test_done();
    end
  end
  // Read data lands one cycle after its address
  always @(posedge sys_clk) rd_seen <= rd_go;
  always @(negedge sys_clk) begin
    if (rd_seen) begin
      e = exp_q.pop_front();
      `CHK("rd_data", e, rd_data)
    end
  end
  task rd(input logic [15:0] a, input logic [7:0] x);
    @(negedge sys_clk);
    rd_addr = a;
    rd_go = 1'b1;
    exp_q.push_back(x);
    @(negedge sys_clk);
    rd_go = 1'b0;
  endtask
  // One request; returns once the cpu end is ready again
  task req(input logic er, input logic [15:0] a, input logic [7:0] d);
    int n;
    @(negedge sys_clk);
    {req_valid, req_erase, req_addr, req_data} = {1'b1, er, a, d};
    while (req_ready !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
    req_valid = 1'b0;
    @(negedge sys_clk);
    `CHK("busy", er || (a >= fiap_pkg::IAP_BASE && a <= fiap_pkg::IAP_LAST), busy)
    n = 0;
    while (req_ready !== 1'b1 || n < 3) begin
      @(negedge sys_clk);
      n++;
    end
  endtask
  // Bad strobe on the lone end: must not stall
  task poke(input logic [7:0] c, input logic [7:0] w, input logic [15:0] a);
    @(negedge sys_clk);
    {bus2.iap_command_key, bus2.iap_write_enable_key, bus2.xwr_addr} = {c, w, a};
    bus2.xwr_valid = 1'b1;
    #1 `CHK("cpu_wait2", 1'b0, bus2.cpu_wait)
    @(negedge sys_clk);
    bus2.xwr_valid = 1'b0;
  endtask
  initial begin
    {bus2.xwr_valid, bus2.xwr_addr, bus2.xwr_data, bus2.code_addr} = '0;
    {bus2.iap_command_key, bus2.iap_write_enable_key} = '0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    @(negedge sys_clk);
    `CHK("cfg", 8'hff, cfg)
    `CHK("cfg2", 8'hff, cfg2)
    rd(16'h0000, 8'hff);
    req(1'b1, fiap_pkg::TRIG_LO, 8'h3c);
    req(1'b1, fiap_pkg::TRIG_HI, 8'hc3);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      wd[i] = rnd[7:0];
      req(1'b0, wa[i], wd[i]);
      rd(wa[i], wd[i]);
    end
    req(1'b0, 16'h79ff, 8'h00);
    rd(16'h79ff, 8'hff);
    req(1'b0, 16'h7e00, 8'h00);
    rd(16'h7e00, 8'hff);
    req(1'b1, fiap_pkg::TRIG_LO, 8'h00);
    rd(16'h7a00, 8'hff);
    rd(16'h7b2d, 8'hff);
    rd(16'h7c00, wd[2]);
    `CHK("ign", 8'h00, ign)
    poke(8'h00, fiap_pkg::WE_WRITE_LO, 16'h7a00);
    poke(fiap_pkg::CMD_KEY, fiap_pkg::WE_ERASE_LO, 16'h7a00);
    poke(fiap_pkg::CMD_KEY, fiap_pkg::WE_WRITE_LO, 16'h7c00);
    poke(fiap_pkg::CMD_KEY, fiap_pkg::WE_ERASE_HI, fiap_pkg::TRIG_LO);
    bus2.code_addr = 16'h7a00;
    repeat (2) @(negedge sys_clk);
    `CHK("ign2", 8'h04, ign2)
    `CHK("busy2", 1'b0, busy2)
    `CHK("code_data2", 8'hff, bus2.code_data)
    repeat (3) @(negedge sys_clk);
    test_done();
  end
endmodule
